// ==== sars_regs.vh ====
// Constants for the successive-approximation converter readout block
`ifndef SARS_REGS_VH
`define SARS_REGS_VH
`define SARS_CODE_W        18
`define SARS_MSB           17
`define SARS_CLK_PERIOD_NS 10
`define SARS_CONV_TIME_NS  360
`define SARS_CONV_CYCLES   ((`SARS_CONV_TIME_NS + `SARS_CLK_PERIOD_NS - 1) / `SARS_CLK_PERIOD_NS)
`define SARS_STEP_CYCLES   (`SARS_CONV_CYCLES / `SARS_CODE_W)
`define SARS_STEP_CNT_W    5
`define SARS_BIT_CNT_W     5
`define SARS_GAIN_NUM      13
`define SARS_GAIN_SHIFT    4
`endif

// ==== sars_adc_readout.v ====
// Conversion control and serial readout of an 18-bit converter
`timescale 1ns/10ps
`default_nettype none
`include "sars_regs.vh"

module sars_adc_readout (
  input  wire                     clock,
  input  wire                     reset_n,
  input  wire                     convertStart,
  input  wire                     serialClock,
  input  wire                     readEnableOrUpstreamIn,
  input  wire                     chainSelect,
  input  wire                     compressionStrap,
  input  wire                     compareIn,
  output reg  [`SARS_MSB:0]       capDacTrial,
  output reg                      busy,
  output reg                      poweredUp,
  output reg                      serialOut,
  output wire                     serialOutEnable_n
);

  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_DONE = 2'b10;
  localparam [`SARS_BIT_CNT_W-1:0]          LAST_BIT = `SARS_MSB;
  localparam [`SARS_MSB+`SARS_GAIN_SHIFT:0] GAIN_NUM = `SARS_GAIN_NUM;

  reg  [1:0]                   cnvSync;
  reg                          cnvLast;
  reg  [1:0]                   sckSync;
  reg                          sckLast;
  reg  [1:0]                   rdSync;
  reg  [1:0]                   chainSync;
  reg  [1:0]                   strapSync;
  reg  [1:0]                   state;
  reg  [`SARS_STEP_CNT_W-1:0]  stepCnt;
  reg  [`SARS_BIT_CNT_W-1:0]   bitIdx;
  reg  [`SARS_MSB:0]           sarCode;
  reg  [`SARS_MSB:0]           shiftReg;
  wire                         cnvRise;
  wire                         sckRise;
  wire                         stepTick;
  wire [`SARS_MSB:0]           trialCode;
  wire [`SARS_MSB:0]           finalCode;
  wire [`SARS_MSB:0]           resolvedCode;
  wire                         lastStep;

  function [`SARS_MSB:0] flip_sign;
    input [`SARS_MSB:0] code;
    begin
      // Offset binary to two's complement
      flip_sign = {~code[`SARS_MSB], code[`SARS_MSB-1:0]};
    end
  endfunction

  function [`SARS_MSB:0] compress;
    input [`SARS_MSB:0] twosCode;
    reg   [`SARS_MSB+`SARS_GAIN_SHIFT:0] prod;
    begin
      // Signed scale by gain ratio about zero code
      prod     = {{`SARS_GAIN_SHIFT{twosCode[`SARS_MSB]}}, twosCode} * GAIN_NUM;
      compress = prod[`SARS_MSB+`SARS_GAIN_SHIFT:`SARS_GAIN_SHIFT];
    end
  endfunction

  assign cnvRise      = cnvSync[1] & ~cnvLast;
  assign sckRise      = sckSync[1] & ~sckLast;
  assign stepTick     = (stepCnt == `SARS_STEP_CYCLES - 1);
  assign lastStep     = (state == ST_CONV) && stepTick && (bitIdx == 0);
  assign trialCode    = sarCode | ({{`SARS_MSB{1'b0}}, 1'b1} << bitIdx);
  // Comparator decision applied to the current trial
  assign resolvedCode = compareIn ? trialCode : sarCode;
  // Two's complement result, compressed when strap low
  assign finalCode    = strapSync[1] ? flip_sign(resolvedCode)
                      : compress(flip_sign(resolvedCode));

  // Normal mode: driven while enable low; chain mode: always driven
  assign serialOutEnable_n = chainSync[1] ? 1'b0 : rdSync[1];

  // Convert pin synchroniser
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnvSync <= 2'b00;
      cnvLast <= 1'b0;
    end else begin
      cnvSync <= {cnvSync[0], convertStart};
      cnvLast <= cnvSync[1];
    end
  end

  // Serial clock synchroniser
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sckSync <= 2'b00;
      sckLast <= 1'b0;
    end else begin
      sckSync <= {sckSync[0], serialClock};
      sckLast <= sckSync[1];
    end
  end

  // Shared pin synchroniser
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdSync <= 2'b11;
    end else begin
      rdSync <= {rdSync[0], readEnableOrUpstreamIn};
    end
  end

  // Chain select synchroniser
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chainSync <= 2'b00;
    end else begin
      chainSync <= {chainSync[0], chainSelect};
    end
  end

  // Strap synchroniser
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strapSync <= 2'b11;
    end else begin
      strapSync <= {strapSync[0], compressionStrap};
    end
  end

  // Conversion sequencer
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_IDLE;
      stepCnt     <= {`SARS_STEP_CNT_W{1'b0}};
      bitIdx      <= {`SARS_BIT_CNT_W{1'b0}};
      sarCode     <= {`SARS_CODE_W{1'b0}};
      capDacTrial <= {`SARS_CODE_W{1'b0}};
      busy        <= 1'b0;
      poweredUp   <= 1'b0;
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          if (cnvRise) begin
            state       <= ST_CONV;
            poweredUp   <= 1'b1;
            busy        <= 1'b1;
            stepCnt     <= {`SARS_STEP_CNT_W{1'b0}};
            bitIdx      <= LAST_BIT;
            sarCode     <= {`SARS_CODE_W{1'b0}};
            capDacTrial <= {1'b1, {`SARS_MSB{1'b0}}};
          end
        end
        ST_CONV: begin
          if (stepTick) begin
            stepCnt <= {`SARS_STEP_CNT_W{1'b0}};
            sarCode <= resolvedCode;
            if (bitIdx == 0) begin
              state     <= ST_DONE;
              busy      <= 1'b0;
              poweredUp <= 1'b0;
            end else begin
              bitIdx      <= bitIdx - 1'b1;
              capDacTrial <= resolvedCode
                           | ({{`SARS_MSB{1'b0}}, 1'b1} << (bitIdx - 1'b1));
            end
          end else begin
            stepCnt <= stepCnt + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Result load at conversion end, shift on each serial clock rise outside conversion except in a convert start cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shiftReg  <= {`SARS_CODE_W{1'b0}};
      serialOut <= 1'b0;
    end else if (lastStep) begin
      shiftReg  <= finalCode;
      serialOut <= finalCode[`SARS_MSB];
    end else if (state != ST_CONV && !cnvRise && sckRise) begin
      // Chain mode takes upstream data into the low end
      shiftReg  <= {shiftReg[`SARS_MSB-1:0], chainSync[1] & rdSync[1]};
      serialOut <= shiftReg[`SARS_MSB-1];
    end
  end

endmodule // sars_adc_readout
`default_nettype wire

// ==== sars_adc_readout_monitor.sv ====
// Port checker for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module sars_adc_readout_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic convertStart,
  input wire logic serialClock,
  input wire logic readEnableOrUpstreamIn,
  input wire logic chainSelect,
  input wire logic compressionStrap,
  input wire logic busy,
  input wire logic poweredUp,
  input wire logic serialOut,
  input wire logic serialOutEnable_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_BUSY_UP:
    assert property ($rose(convertStart) && !busy |-> ##[1:6] busy) else $error("busy late");
  AST_BUSY_LEN:
    assert property ($rose(busy) |-> busy[*8] ##27 busy ##[1:2] !busy) else $error("busy length");
  AST_WAKE:
    assert property ($rose(convertStart) && !busy |-> ##[1:6] poweredUp) else $error("no wake");
  AST_SLEEP:
    assert property ($fell(busy) |-> ##[0:2] !poweredUp) else $error("no sleep");
  AST_EN_OFF:
    assert property ((!chainSelect && readEnableOrUpstreamIn)[*4] |-> serialOutEnable_n) else $error("oe on");
  AST_EN_ON:
    assert property ((!chainSelect && !readEnableOrUpstreamIn)[*4] |-> !serialOutEnable_n) else $error("oe off");
  AST_CHAIN_EN:
    assert property (chainSelect[*4] |-> !serialOutEnable_n) else $error("chain oe");
  AST_OUT_HOLD:
    assert property ((!busy && !serialClock)[*3] |-> $stable(serialOut)) else $error("out moved");
  cover property (chainSelect && $fell(busy));
  cover property (!compressionStrap && $fell(busy));
  cover property ($rose(serialClock) && !serialOutEnable_n);
endmodule // sars_adc_readout_monitor
bind sars_adc_readout sars_adc_readout_monitor i_mon (.clock(clock), .reset_n(reset_n),
  .convertStart(convertStart), .serialClock(serialClock), .readEnableOrUpstreamIn(readEnableOrUpstreamIn),
  .chainSelect(chainSelect), .compressionStrap(compressionStrap), .busy(busy), .poweredUp(poweredUp),
  .serialOut(serialOut), .serialOutEnable_n(serialOutEnable_n));
`default_nettype wire

// ==== sars_host_model.sv ====
// Host controller model: convert, serial clock, shared pin
`timescale 1ns/10ps
`default_nettype none
module sars_host_model (
  input  wire logic        clock,
  input  wire logic        busy,
  input  wire logic        chainSelect,
  input  wire logic        serialOut,
  input  wire logic [17:0] upWord,
  output var  logic        convertStart,
  output var  logic        serialClock,
  output var  logic        pinShared
);
  initial begin
    convertStart = 0;
    serialClock = 0;
    pinShared = 1;
  end
  task automatic frame(input int n, output logic [35:0] got);
    int k;
    got = '0;
    @(posedge clock) convertStart <= 1;
    repeat (3) @(posedge clock);
    convertStart <= 0;
    for (k = 0; k < 60 && !busy; k++) @(posedge clock);
    for (k = 0; k < 80 && busy; k++) @(posedge clock);
    pinShared <= chainSelect ? upWord[17] : 1'b0;
    for (k = 0; k < n; k++) begin
      repeat (4) @(posedge clock);
      got = {got[34:0], serialOut};
      serialClock <= 1;
      repeat (4) @(posedge clock);
      serialClock <= 0;
      pinShared <= (chainSelect && k < 17) ? upWord[16-k] : ~pinShared;
    end
    repeat (4) @(posedge clock);
    pinShared <= chainSelect ? ~pinShared : 1'b1;
  endtask
endmodule // sars_host_model
`default_nettype wire

// ==== sars_adc_readout_tb.sv ====
// Self-checking bench for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module sars_adc_readout_tb;
  logic        clock = 0, reset_n = 0, compareIn = 0, chain = 0, strap = 1;
  logic        busy, poweredUp, serialOut, oeN, conv, sck, pin;
  logic [17:0] trial, target = 0, upWord = 0;
  logic [35:0] got;
  logic [17:0] expQ[$];
  integer      err_total = 0, check_count = 0, cycles = 0, seed = 32'heb2b1221, i, v;
  initial forever #5 clock = ~clock;
  always @(posedge clock) compareIn <= (trial <= (target ^ 18'h20000));
  always @(posedge clock) if (++cycles == 10000) begin err_total++; wrap_up; end
  sars_adc_readout i_sars_adc_readout (.clock(clock), .reset_n(reset_n), .convertStart(conv), .serialClock(sck),
    .readEnableOrUpstreamIn(pin), .chainSelect(chain), .compressionStrap(strap), .compareIn(compareIn),
    .capDacTrial(trial), .busy(busy), .poweredUp(poweredUp), .serialOut(serialOut), .serialOutEnable_n(oeN));
  sars_host_model i_sars_host_model (.clock(clock), .busy(busy), .chainSelect(chain), .serialOut(serialOut),
    .upWord(upWord), .convertStart(conv), .serialClock(sck), .pinShared(pin));
  task check(input logic [17:0] seen, input logic [17:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1;
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      chain <= i[0];
      strap <= !i[1];
      target <= (i < 2) ? (18'h20000 ^ {18{i[0]}}) : 18'($random(seed));
      upWord <= 18'($random(seed));
      repeat (8) @(posedge clock);
      v = $signed(target);
      if (!strap) v = (v * 13) >>> 4;
      expQ.push_back(v[17:0]);
      if (chain) expQ.push_back(upWord);
      i_sars_host_model.frame(chain ? 36 : 18, got);
      check(chain ? got[35:18] : got[17:0], expQ.pop_front());
      if (chain) check(got[17:0], expQ.pop_front());
      $display("test %0d done", i);
    end
    wrap_up;
  end
endmodule // sars_adc_readout_tb
`default_nettype wire
